// File: rtc_trim_alarm_wdog.sv
// rtc trim, alarm, watchdog and interrupt logic behind an ahb-lite slave
`timescale 1ns/100ps

// Behaviour
// R1: five-bit trim magnitude, bit five gives sign
// R2: 64-minute cycle; shorten 128 or lengthen 256
// R3: only first 2N minutes get trimmed
// R4: positive adds counts, negative suppresses counts
// R5: test bit toggles pin at untrimmed 512 Hz
// R6: flag register writable only under update hold
// R7: alarm match sets flag, pin if enabled
// R8: field takes part only when exclude bit clear
// R9: reading flag register clears all event flags
// R10: alarm settings take effect when hold clears
// R11: host keeps seconds exclude bit at zero
// R12: watchdog ticks 32 Hz, frozen with oscillator stopped
// R13: watchdog loads at power up, reloads on kick
// R14: watchdog zero sets flag, pin if enabled
// R15: timeout value writes ignored while lock set
// R16: timeout value zero disables the watchdog
// R17: bus access blocked on backup, counting continues
// R18: pin needs flag and matching enable bit
// R19: pulse about 200 ms, level until read
// R20: no interrupts while on backup supply
// R21: host ignores pin during power-up recall
// R22: polarity one push-pull high, zero open-drain low
// R23: pulse mode when one, level mode when zero
// R24: flag read cuts an interrupt pulse short
// R25: supply failure sets the supply fail flag
// R26: host writes reach counters on oscillator ticks
module rtc_trim_alarm_wdog #(
  parameter int PULSE_LEN = rtc_pkg::PULSE_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // oscillator and supply
  input wire logic osc_tick,
  input wire logic osc_running,
  input wire logic on_backup,
  input wire logic power_fail,
  input wire rtc_pkg::time_now_t time_now,
  // outputs
  output logic sec_tick,
  output logic int_pin_out,
  output logic int_pin_oe
);
  import rtc_pkg::*;

  // whole module state
  typedef struct packed {
    logic [7:0] flags;          // wdf af pf - 0 cal hold read
    logic [3:0][7:0] alm_sh;    // alarm as written by host
    logic [3:0][7:0] alm_act;   // alarm used by the comparator
    logic [7:0] int_ctl;        // interrupt enables and pin mode
    logic [6:0] wd_ctl;         // lock and timeout value
    logic [7:0] trim;           // trim as written by host
    logic [5:0] trim_act;       // trim in use for this second
    logic kick_pend;            // kick waiting for next tick
    logic wd_load_pend;         // power-up load waiting
    logic [5:0] wd_cnt;         // watchdog down counter
    logic [9:0] presc;          // untrimmed oscillator divider
    logic [16:0] sec_cnt;       // trimmed count within second
    logic [5:0] sec_idx;        // second within minute
    logic [5:0] min_idx;        // minute within trim cycle
    logic test_lvl;             // 512 Hz test square wave
    logic match_q;              // alarm match last cycle
    logic irq_req_q;            // enabled source last cycle
    irq_state_t irq_st;         // pin sequencer
    logic [25:0] pulse_cnt;     // remaining pulse cycles
    logic dph_wr;               // write data phase pending
    logic [14:0] dph_idx;       // index of that write
    logic [31:0] rdata;
    logic tick_out;
    logic pin_out;
    logic pin_oe;
  } st_t;

  st_t s_q;
  st_t s_d;

  // register index from a byte address; -1 style miss when misaligned
  function automatic logic [15:0] reg_index(input logic [31:0] a);
    if (a[31:17] != 15'h0000 || a[1:0] != 2'h0) begin
      reg_index = 16'hFFFF;
    end else begin
      reg_index = {1'b0, a[16:2]};
    end
  endfunction

  // alarm slot from register index; 3'h4 means not an alarm register
  function automatic logic [2:0] alarm_slot(input logic [15:0] i);
    if (i == {1'b0, IDX_ALARM_SECONDS}) begin
      alarm_slot = 3'h0;
    end else if (i == {1'b0, IDX_ALARM_MINUTES}) begin
      alarm_slot = 3'h1;
    end else if (i == {1'b0, IDX_ALARM_HOURS}) begin
      alarm_slot = 3'h2;
    end else if (i == {1'b0, IDX_ALARM_DATE}) begin
      alarm_slot = 3'h3;
    end else begin
      alarm_slot = 3'h4;
    end
  endfunction

  // per-field alarm compare, seconds at slot 0 up to date at slot 3
  logic [3:0][6:0] now_f;
  logic [3:0] fld_ok;
  logic [3:0] fld_in;
  assign now_f[0] = time_now.seconds[6:0];
  assign now_f[1] = time_now.minutes[6:0];
  assign now_f[2] = time_now.hours[6:0];
  assign now_f[3] = time_now.date[6:0];

  // fields compare on bits 6:0; bit 7 is the exclude mark
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_alm
      // an excluded field always agrees
      assign fld_in[g] = ~s_q.alm_act[g][ALM_EXCLUDE]; // R8
      assign fld_ok[g] = ~fld_in[g] |
                         (s_q.alm_act[g][6:0] == now_f[g]); // R7
    end
  endgenerate

  // all fields excluded never fires; one included field is enough
  logic alarm_match;
  assign alarm_match = (|fld_in) & (&fld_ok); // R8

  // next state
  always_comb begin
    logic [15:0] aidx;
    logic [15:0] widx;
    logic [2:0] slot;
    logic tick;
    logic wd_tick;
    logic sec_end;
    logic trim_min;
    logic [16:0] sec_len;
    logic flag_rd;
    logic wd_hit;
    logic irq_req;
    logic active;
    // every local gets a value first so no path leaves a latch
    aidx = reg_index(haddr);
    widx = {1'b0, s_q.dph_idx};
    slot = 3'h0;
    tick = 1'b0;
    wd_tick = 1'b0;
    sec_end = 1'b0;
    trim_min = 1'b0;
    sec_len = OSC_PER_SEC;
    flag_rd = 1'b0;
    wd_hit = 1'b0;
    irq_req = 1'b0;
    active = 1'b0;
    s_d = s_q;
    s_d.tick_out = 1'b0;
    // stopped oscillator gives no counts at all
    tick = osc_tick & osc_running; // R12

    // the test wave and the watchdog use the raw divider, so a
    // trim setting can never move their rates
    // untrimmed divider for the test wave and the watchdog rate
    wd_tick = 1'b0;
    if (tick) begin
      s_d.presc = s_q.presc + 10'h001;
      if (s_q.presc[4:0] == TEST_HALF_PERIOD) begin
        s_d.test_lvl = ~s_q.test_lvl; // R5
      end
      wd_tick = (s_q.presc == 10'h3FF); // R12
    end

    // minute index wraps by itself at 64, closing the trim cycle
    // trimmed second: first second of an early minute is altered
    trim_min = (s_q.min_idx < {s_q.trim_act[4:0], 1'b0}) && // R3
               (s_q.min_idx < TRIM_MINUTES); // R2
    sec_len = OSC_PER_SEC;
    if (trim_min && s_q.sec_idx == 6'h00) begin
      if (s_q.trim_act[TRIM_SIGN]) begin
        sec_len = OSC_PER_SEC + TRIM_LENGTHEN; // R4
      end else begin
        sec_len = OSC_PER_SEC - TRIM_SHORTEN; // R4
      end
    end
    sec_end = tick && (s_q.sec_cnt == sec_len - 17'h00001);
    if (tick) begin
      s_d.sec_cnt = s_q.sec_cnt + 17'h00001;
    end
    if (sec_end) begin
      s_d.sec_cnt = 17'h00000;
      s_d.tick_out = 1'b1;
      // new trim only at a second boundary so no count is split
      s_d.trim_act = s_q.trim[5:0]; // R26
      if (s_q.sec_idx == SECS_PER_MIN - 6'h01) begin
        s_d.sec_idx = 6'h00;
        s_d.min_idx = s_q.min_idx + 6'h01; // R2
      end else begin
        s_d.sec_idx = s_q.sec_idx + 6'h01;
      end
    end

    // watchdog: kicks and the power-up load land on an oscillator tick
    // a timeout write alone leaves the running count untouched;
    // a kick, or the next expiry, restarts it from the new value
    if (tick && (s_q.wd_load_pend || s_q.kick_pend)) begin
      s_d.wd_cnt = s_q.wd_ctl[5:0]; // R13
      s_d.wd_load_pend = 1'b0;
      s_d.kick_pend = 1'b0; // R26
    end else if (wd_tick && s_q.wd_ctl[5:0] != 6'h00) begin // R16
      if (s_q.wd_cnt <= 6'h01) begin
        // expiry, then free-run again from the timeout value
        wd_hit = 1'b1; // R14
        s_d.wd_cnt = s_q.wd_ctl[5:0];
      end else begin
        s_d.wd_cnt = s_q.wd_cnt - 6'h01; // R12
      end
    end

    // writes land at the end of their data phase, when hwdata stands
    // ahb data phase of a write
    if (s_q.dph_wr && !on_backup) begin // R17
      slot = alarm_slot(widx);
      if (widx == {1'b0, IDX_EVENT_FLAGS}) begin
        // hold bit always writable; test and read bits only while hold is set
        s_d.flags[FLG_HOLD] = hwdata[FLG_HOLD];
        if (s_q.flags[FLG_HOLD]) begin
          s_d.flags[FLG_TEST] = hwdata[FLG_TEST]; // R6
          s_d.flags[FLG_READ] = hwdata[FLG_READ];
        end
        if (s_q.flags[FLG_HOLD] && !hwdata[FLG_HOLD]) begin
          s_d.alm_act = s_q.alm_sh; // R10
        end
      end else if (slot != 3'h4) begin
        // kept aside until hold drops back
        s_d.alm_sh[slot[1:0]] = hwdata[7:0]; // R10
      end else if (widx == {1'b0, IDX_INTERRUPT_CONTROL}) begin
        s_d.int_ctl = hwdata[7:0] & 8'hEC;
      end else if (widx == {1'b0, IDX_WATCHDOG_CONTROL}) begin
        s_d.wd_ctl[6] = hwdata[WD_LOCK];
        if (!hwdata[WD_LOCK]) begin
          s_d.wd_ctl[5:0] = hwdata[5:0]; // R15
        end
        if (hwdata[WD_KICK]) begin
          s_d.kick_pend = 1'b1; // R13
        end
      end else if (widx == {1'b0, IDX_CLOCK_TRIM}) begin
        s_d.trim = hwdata[7:0] & 8'hBF; // R1
      end
    end

    // hsize is not decoded; every register is one aligned word
    // ahb address phase; zero wait states, read data ready next edge
    s_d.dph_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_d.dph_wr = hwrite;
      s_d.dph_idx = aidx[14:0];
      s_d.rdata = 32'h0000_0000;
      if (!hwrite && !on_backup) begin // R17
        slot = alarm_slot(aidx);
        if (aidx == {1'b0, IDX_EVENT_FLAGS}) begin
          s_d.rdata[7:0] = s_q.flags;
          flag_rd = 1'b1; // R9
        end else if (slot != 3'h4) begin
          s_d.rdata[7:0] = s_q.alm_sh[slot[1:0]];
        end else if (aidx == {1'b0, IDX_INTERRUPT_CONTROL}) begin
          s_d.rdata[7:0] = s_q.int_ctl;
        end else if (aidx == {1'b0, IDX_WATCHDOG_CONTROL}) begin
          s_d.rdata[7:0] = {1'b0, s_q.wd_ctl};
        end else if (aidx == {1'b0, IDX_CLOCK_TRIM}) begin
          s_d.rdata[7:0] = s_q.trim;
        end
      end
    end

    // the clear sits above the sets so a same-cycle event survives
    // event flags: a read clears, a same-cycle event still sets
    if (flag_rd) begin
      s_d.flags[FLG_WDOG] = 1'b0; // R9
      s_d.flags[FLG_ALARM] = 1'b0; // R9
      s_d.flags[FLG_SUPPLY] = 1'b0; // R9
    end
    s_d.match_q = alarm_match;
    if (alarm_match && !s_q.match_q) begin
      s_d.flags[FLG_ALARM] = 1'b1; // R7
    end
    if (wd_hit) begin
      s_d.flags[FLG_WDOG] = 1'b1; // R14
    end
    if (power_fail) begin
      s_d.flags[FLG_SUPPLY] = 1'b1; // R25
    end

    // enabled source present, and only on main supply
    irq_req = ~on_backup & ( // R20
      (s_q.flags[FLG_WDOG] & s_q.int_ctl[INT_WDOG_EN]) |
      (s_q.flags[FLG_ALARM] & s_q.int_ctl[INT_ALARM_EN]) |
      (s_q.flags[FLG_SUPPLY] & s_q.int_ctl[INT_SUPPLY_EN])); // R18
    s_d.irq_req_q = irq_req;

    // pulse counter width covers the default length at 200 MHz
    // pulse sequencer
    case (s_q.irq_st)
      IRQ_IDLE: begin
        // only a rising request starts a pulse; a source that stays
        // set does not retrigger until its flag is read
        if (irq_req && !s_q.irq_req_q && s_q.int_ctl[INT_PULSE]) begin
          s_d.irq_st = IRQ_PULSE; // R23
          s_d.pulse_cnt = 26'(PULSE_LEN - 1); // R19
        end
      end
      IRQ_PULSE: begin
        if (flag_rd || on_backup || s_q.pulse_cnt == 26'h0000000) begin
          s_d.irq_st = IRQ_IDLE; // R24
        end else begin
          s_d.pulse_cnt = s_q.pulse_cnt - 26'h0000001; // R19
        end
      end
      default: begin
        s_d.irq_st = IRQ_IDLE;
      end
    endcase

    // active level: test wave, pulse, or held level
    if (s_q.flags[FLG_TEST]) begin
      active = s_q.test_lvl; // R5
    end else if (s_q.int_ctl[INT_PULSE]) begin
      active = (s_q.irq_st == IRQ_PULSE); // R23
    end else begin
      active = irq_req; // R19
    end

    // open-drain mode never drives high; the board pull-up does
    // push-pull active high, or open-drain pulling low
    if (s_q.int_ctl[INT_POLARITY]) begin
      s_d.pin_out = active; // R22
      s_d.pin_oe = 1'b1;
    end else begin
      s_d.pin_out = 1'b0; // R22
      s_d.pin_oe = active;
    end
  end

  // state register; power-up load of the watchdog is queued here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.alm_sh <= {4{RST_ALARM}};
      s_q.alm_act <= {4{RST_ALARM}};
      s_q.int_ctl <= RST_INTERRUPT_CONTROL;
      s_q.wd_ctl <= RST_WATCHDOG_CONTROL[6:0];
      s_q.trim <= RST_CLOCK_TRIM;
      s_q.wd_load_pend <= 1'b1; // R13
      s_q.irq_st <= IRQ_IDLE;
      s_q.pin_oe <= 1'b1; // defaults to push-pull inactive low
    end else begin
      s_q <= s_d;
    end
  end

  // bus and pin outputs from the state register; hreadyout held high, hresp low
  always_comb begin
    hrdata = s_q.rdata;
    hreadyout = ~s_q.dph_wr | 1'b1;
    hresp = 1'b0;
    sec_tick = s_q.tick_out;
    int_pin_out = s_q.pin_out;
    int_pin_oe = s_q.pin_oe;
  end

endmodule

// File: rtc_pkg.sv
// shared constants and types for the rtc trim, alarm and watchdog block
package rtc_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [14:0] IDX_EVENT_FLAGS = 15'h7FF0;
  localparam logic [14:0] IDX_ALARM_SECONDS = 15'h7FF2;
  localparam logic [14:0] IDX_ALARM_MINUTES = 15'h7FF3;
  localparam logic [14:0] IDX_ALARM_HOURS = 15'h7FF4;
  localparam logic [14:0] IDX_ALARM_DATE = 15'h7FF5;
  localparam logic [14:0] IDX_INTERRUPT_CONTROL = 15'h7FF6;
  localparam logic [14:0] IDX_WATCHDOG_CONTROL = 15'h7FF7;
  localparam logic [14:0] IDX_CLOCK_TRIM = 15'h7FF8;

  // event_flags bit positions
  localparam int FLG_WDOG = 7;
  localparam int FLG_ALARM = 6;
  localparam int FLG_SUPPLY = 5;
  localparam int FLG_TEST = 2;
  localparam int FLG_HOLD = 1;
  localparam int FLG_READ = 0;

  // interrupt_control bit positions
  localparam int INT_WDOG_EN = 7;
  localparam int INT_ALARM_EN = 6;
  localparam int INT_SUPPLY_EN = 5;
  localparam int INT_POLARITY = 3;
  localparam int INT_PULSE = 2;

  // watchdog_control, clock_trim and alarm fields
  localparam int WD_KICK = 7;
  localparam int WD_LOCK = 6;
  localparam int TRIM_SIGN = 5;
  localparam int ALM_EXCLUDE = 7;

  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h08;
  localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_TRIM = 8'h00;
  localparam logic [7:0] RST_ALARM = 8'h80;

  // oscillator counts
  localparam logic [16:0] OSC_PER_SEC = 17'h08000;
  localparam logic [16:0] TRIM_SHORTEN = 17'h00080;
  localparam logic [16:0] TRIM_LENGTHEN = 17'h00100;
  localparam logic [5:0] SECS_PER_MIN = 6'h3C;
  localparam logic [5:0] TRIM_MINUTES = 6'h3E;
  localparam logic [4:0] TEST_HALF_PERIOD = 5'h1F;

  // interrupt pulse width
  localparam int PULSE_MS = 200;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;

  // current calendar time, bcd, from the clock counters
  typedef struct packed {
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_now_t;

  // interrupt pin sequencer states
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b01,
    IRQ_PULSE = 2'b10
  } irq_state_t;

endpackage

// File: host_pin_model.sv
// host side model: resolves the interrupt line and counts its edges
`timescale 1ns/100ps
module host_pin_model (
  // clock
  input wire logic hclk,
  // pin from the block
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  // high during power-up recall, also clears the count
  input wire logic ignore_pin,
  // host view
  output logic int_line,
  output logic [15:0] edges_q
);
  logic last_q; // line level one cycle ago
  // pull-up holds the released open-drain line high
  assign int_line = int_pin_oe ? int_pin_out : 1'b1;
  // count toggles; anything during recall is dropped
  always @(posedge hclk) begin
    last_q <= int_line;
    if (ignore_pin)
      edges_q <= 16'h0000;
    else if (int_line !== last_q)
      edges_q <= edges_q + 16'h0001;
  end
endmodule

// File: rtc_trim_alarm_wdog_asserts.sv
// concurrent checks on the rtc block ports
`timescale 1ns/100ps
module rtc_trim_alarm_wdog_asserts #(
  parameter int PULSE_LEN = 20
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // oscillator, supply and pin
  input wire logic osc_tick,
  input wire logic osc_running,
  input wire logic on_backup,
  input wire logic sec_tick,
  input wire logic int_pin_out,
  input wire logic int_pin_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int span_q; // running oscillator ticks since last second end
  // span counter; slack of two covers pipeline phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      span_q <= 0;
    else if (sec_tick)
      span_q <= (osc_tick && osc_running) ? 1 : 0;
    else if (osc_tick && osc_running)
      span_q <= span_q + 1;
  end
  AST_ZERO_WAIT: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave gave a non-okay response");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_BACKUP_READ: assert property (
    hsel && htrans[1] && hready && !hwrite && on_backup |=> hrdata == 32'h0)
    else $error("read on backup returned data");
  AST_PUSH_PULL: assert property (int_pin_out |-> int_pin_oe)
    else $error("pin high without drive enable");
  AST_BACKUP_QUIET: assert property (on_backup [*3] |-> !int_pin_out)
    else $error("interrupt pin active on backup");
  AST_OSC_STOP: assert property (
    !osc_running ##1 !osc_running |-> !sec_tick)
    else $error("second ended with oscillator stopped");
  AST_SEC_PULSE: assert property (sec_tick |=> !sec_tick)
    else $error("second pulse longer than a cycle");
  AST_SEC_SPAN: assert property (
    sec_tick |-> span_q >= 32638 && span_q <= 33026)
    else $error("second length outside trim range");
  C_SEC: cover property (sec_tick);
  C_PIN_HIGH: cover property (int_pin_out && int_pin_oe);
  C_BACKUP_RD: cover property (hsel && htrans[1] && on_backup);
  C_RELEASE: cover property ($fell(int_pin_oe));
endmodule

bind rtc_trim_alarm_wdog rtc_trim_alarm_wdog_asserts #(
  .PULSE_LEN(PULSE_LEN)
) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .osc_tick(osc_tick),
  .osc_running(osc_running), .on_backup(on_backup),
  .sec_tick(sec_tick), .int_pin_out(int_pin_out),
  .int_pin_oe(int_pin_oe)
);

// File: rtc_trim_alarm_wdog_tb.sv
// self-checking bench for the rtc trim, alarm and watchdog block
`timescale 1ns/100ps
module rtc_trim_alarm_wdog_tb;
  import rtc_pkg::*;
  localparam int PL = 20; // short pulse keeps the run brief
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sec_tick, int_pin_out, int_pin_oe, int_line;
  logic osc_tick = 1'b0;
  logic osc_running = 1'b1;
  logic on_backup = 1'b0;
  logic power_fail = 1'b0;
  logic ignore_pin = 1'b1; // recall interval until the test wave scenario
  logic [15:0] edges_q;
  time_now_t time_now = 32'h01021729; // minutes set to catch misuse
  logic [7:0] rd; // last read byte
  int n_fail = 0;
  int samples_checked = 0;
  // clock, and an oscillator count every other cycle
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) osc_tick <= ~osc_tick;
  rtc_trim_alarm_wdog #(.PULSE_LEN(PL)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .osc_tick(osc_tick), .osc_running(osc_running),
    .on_backup(on_backup), .power_fail(power_fail),
    .time_now(time_now), .sec_tick(sec_tick),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));
  host_pin_model u_host (.hclk(hclk), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .ignore_pin(ignore_pin),
    .int_line(int_line), .edges_q(edges_q));
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait for the line; a must-wait that runs out ends the run
  task automatic wait_line(input logic lvl, input int lim, input bit must,
                           output int n);
    n = 0;
    while (int_line !== lvl && n < lim) begin
      @(posedge hclk);
      n++;
    end
    if (must && n >= lim) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  // edges until hready seen high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  // single word transfer; byte address is four times the index
  task automatic xfer(input logic w, input logic [14:0] idx,
                      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {15'h0, idx, 2'h0};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy;
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [14:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [14:0] idx,
                     input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {24'h0, rd}, {24'h0, e});
  endtask
  // reset values, trim field, unmapped word
  task automatic t_regs;
    rdc("int_ctl", IDX_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
    rdc("wd_ctl", IDX_WATCHDOG_CONTROL, RST_WATCHDOG_CONTROL);
    rdc("alm_sec", IDX_ALARM_SECONDS, RST_ALARM);
    rdc("flags", IDX_EVENT_FLAGS, 8'h00);
    wr(IDX_CLOCK_TRIM, 8'h7F);
    rdc("trim", IDX_CLOCK_TRIM, 8'h3F);
    wr(15'h7FF9, 8'h55);
    rdc("unmapped", 15'h7FF9, 8'h00);
  endtask
  // test wave under update hold; trim must not move it
  task automatic t_test;
    wr(IDX_EVENT_FLAGS, 8'h04);
    rdc("no_hold", IDX_EVENT_FLAGS, 8'h00);
    wr(IDX_EVENT_FLAGS, 8'h02);
    wr(IDX_EVENT_FLAGS, 8'h06);
    rdc("held", IDX_EVENT_FLAGS, 8'h06);
    wr(IDX_CLOCK_TRIM, 8'h25);
    ignore_pin <= 1'b0;
    cycles(640);
    chk("wave", 32'(edges_q >= 9 && edges_q <= 11), 32'h1);
    wr(IDX_EVENT_FLAGS, 8'h00);
    cycles(3);
    chk("wave_off", 32'(int_line), 32'h0);
  endtask
  // seconds alarm, level mode, settings held back until hold clears
  task automatic t_alarm;
    int n;
    time_now.seconds <= 8'h30;
    wr(IDX_INTERRUPT_CONTROL, 8'h48);
    wr(IDX_EVENT_FLAGS, 8'h02);
    wr(IDX_ALARM_SECONDS, 8'h30);
    cycles(4);
    chk("alm_held", 32'(int_line), 32'h0);
    time_now.seconds <= 8'h29;
    wr(IDX_EVENT_FLAGS, 8'h00);
    time_now.seconds <= 8'h30;
    wait_line(1'b1, 10, 1'b1, n);
    cycles(PL + 5);
    chk("level", 32'(int_line), 32'h1);
    rdc("alm_flag", IDX_EVENT_FLAGS, 8'h40);
    cycles(3);
    chk("lvl_clr", 32'(int_line), 32'h0);
    rdc("flag_clr", IDX_EVENT_FLAGS, 8'h00);
  endtask
  // next match: move off the alarm second and back on
  task automatic rematch;
    time_now.seconds <= 8'h29;
    cycles(2);
    time_now.seconds <= 8'h30;
  endtask
  // pulse width, early end by read, backup blocking
  task automatic t_pulse;
    int n;
    wr(IDX_INTERRUPT_CONTROL, 8'h4C);
    rematch;
    wait_line(1'b1, 10, 1'b1, n);
    wait_line(1'b0, PL + 10, 1'b1, n);
    chk("pulse", 32'(n >= PL - 1 && n <= PL + 1), 32'h1);
    rdc("p_flag", IDX_EVENT_FLAGS, 8'h40);
    rematch;
    wait_line(1'b1, 10, 1'b1, n);
    rdc("cut_flag", IDX_EVENT_FLAGS, 8'h40);
    cycles(2);
    chk("cut", 32'(int_line), 32'h0);
    on_backup <= 1'b1;
    rematch;
    cycles(10);
    chk("bk_pin", 32'(int_line), 32'h0);
    rdc("bk_rd", IDX_EVENT_FLAGS, 8'h00);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    on_backup <= 1'b0;
    cycles(2);
    rdc("bk_keep", IDX_EVENT_FLAGS, 8'h40);
    rdc("bk_wr", IDX_INTERRUPT_CONTROL, 8'h4C);
  endtask
  // supply fail flag, masked then enabled
  task automatic t_supply;
    int n;
    wr(IDX_INTERRUPT_CONTROL, 8'h08);
    for (int i = 0; i < 2; i++) begin
      power_fail <= 1'b1;
      cycles(1);
      power_fail <= 1'b0;
      wait_line(1'b1, 6, 1'b0, n);
      chk("pf_pin", 32'(int_line), 32'(i));
      rdc("pf_flag", IDX_EVENT_FLAGS, 8'h20);
      wr(IDX_INTERRUPT_CONTROL, 8'h28);
    end
  endtask
  // watchdog expiry on open-drain pin, kicks, lock, disable
  task automatic t_wdog;
    int n;
    wr(IDX_INTERRUPT_CONTROL, 8'h80);
    wr(IDX_WATCHDOG_CONTROL, 8'h82);
    wait_line(1'b0, 4500, 1'b1, n);
    chk("wd_span", 32'(n > 2000), 32'h1);
    chk("od_low", {30'h0, int_pin_oe, int_pin_out}, 32'h2);
    rdc("wd_flag", IDX_EVENT_FLAGS, 8'h80);
    cycles(3);
    chk("od_free", 32'(int_pin_oe), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_WATCHDOG_CONTROL, 8'hC1);
      wait_line(1'b0, 1800, 1'b0, n);
      chk("kicked", 32'(n), 32'd1800);
    end
    xfer(1'b0, IDX_WATCHDOG_CONTROL, 8'h00);
    chk("locked", {26'h0, rd[5:0]}, 32'h2);
    wr(IDX_WATCHDOG_CONTROL, 8'h00);
    wait_line(1'b0, 4500, 1'b0, n);
    chk("wd_off", 32'(n), 32'd4500);
    rdc("wd_none", IDX_EVENT_FLAGS, 8'h00);
  endtask
  // frozen oscillator, then a second must end
  task automatic t_sec;
    int n;
    osc_running <= 1'b0;
    cycles(300);
    osc_running <= 1'b1;
    n = 0;
    while (sec_tick !== 1'b1 && n < 70000) begin
      @(posedge hclk);
      n++;
    end
    chk("sec", 32'(sec_tick), 32'h1);
  endtask
  // reset for 12 cycles, then the scenarios
  initial begin
    cycles(12);
    hresetn <= 1'b1;
    cycles(1);
    t_regs;
    t_test;
    t_alarm;
    t_pulse;
    t_supply;
    t_wdog;
    t_sec;
    tally_and_finish;
  end
endmodule
